// >>> logic/irq_router_pkg.sv
/*
  Constants, register map and carrier types of the vectored interrupt router.
  Assumes one 50 MHz APB clock domain and an APB master with 32-bit data.

// How it works
// - Fifty-four sources each raise either the normal or the fast request.
// - Thirty-two software-assigned priority slots vector the normal request.
// - Two priority slots vector the fast request.
// - Internal peripheral inputs are level sensitive, active high or active low.
// - GPIO interrupts: high level, low level, rising, falling or both edges.
// - Three external inputs are active-high level requests without edge detection.
// - Any of nineteen GPIO lines may individually act as a source.
// - A software enable mask gates every source on both request paths.
// - Expansion-bus lines 5, 6 and 7 land on sources 22, 33 and 40.
*/
package irq_router_pkg;

  localparam int N_SRC   = 54;
  localparam int N_GPIO  = 19;
  localparam int N_EXT   = 3;
  localparam int N_INT   = 32;
  localparam int N_NSLOT = 32;
  localparam int N_FSLOT = 2;
  localparam int SRC_W   = 6;
  localparam int SLOT_W  = 5;
  localparam int ADDR_W  = 8;
  localparam int N_EVT   = 2;

  // Expansion-bus lines 5, 6 and 7 in source numbering.
  localparam int EXT_SRC5 = 22;
  localparam int EXT_SRC6 = 33;
  localparam int EXT_SRC7 = 40;

  localparam logic [ADDR_W-1:0] OFF_RAW_LO    = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_RAW_HI    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_EN_LO     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_EN_HI     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_ROUTE_LO  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_ROUTE_HI  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_POL_LO    = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_POL_HI    = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_GPIO_EDGE = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_GPIO_POL  = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_GPIO_BOTH = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_GPIO_CLR  = 8'h2C;
  localparam logic [ADDR_W-1:0] OFF_NVEC      = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_FVEC      = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_EVT_STAT  = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_EVT_MASK  = 8'h3C;
  localparam logic [ADDR_W-1:0] OFF_NSLOT     = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_NSLOT_END = 8'hC0;
  localparam logic [ADDR_W-1:0] OFF_FSLOT0    = 8'hC0;
  localparam logic [ADDR_W-1:0] OFF_FSLOT1    = 8'hC4;

  localparam int VEC_VALID_BIT = 31;
  localparam int VEC_SLOT_LSB  = 0;
  localparam int VEC_SRC_LSB   = 8;
  localparam int SLOT_EN_BIT   = 6;
  localparam int EVT_NORMAL    = 0;
  localparam int EVT_FAST      = 1;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef logic [N_SRC-1:0] src_vec_t;

  typedef struct packed {
    logic             en;
    logic [SRC_W-1:0] src;
  } slot_t;

  typedef struct packed {
    logic              valid;
    logic [SLOT_W-1:0] slot;
    logic [SRC_W-1:0]  src;
  } vec_t;

endpackage : irq_router_pkg

// >>> logic/pin_sync.sv
/*
  Three-stage synchroniser for asynchronous pin inputs.
  A bit changes its output only once the second and third stages agree.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 22
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // Stage one feeds only stage two; the agreement check filters single-cycle glitches.
  always_comb begin
    next_level = (stage2 & ~(stage2 ^ stage3)) | (level & (stage2 ^ stage3));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level  <= '0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

endmodule : pin_sync

// >>> logic/slot_picker.sv
/*
  Priority slot scan: reports the lowest-numbered enabled slot whose source is pending.
  Assumes the pending vector is already masked and routed to this request path.
*/
`timescale 1ns/1ps
module slot_picker
  import irq_router_pkg::*;
#(
  parameter int N_SLOTS = 32
) (
  input  wire src_vec_t              pend,
  input  wire slot_t [N_SLOTS-1:0]   slots,
  output vec_t                       vec
);

  // Scanning downward lets the lowest slot number overwrite any higher hit.
  always_comb begin
    vec = '0;
    for (int i = N_SLOTS - 1; i >= 0; i--) begin
      if (slots[i].en && (int'(slots[i].src) < N_SRC) && pend[slots[i].src]) begin
        vec.valid = 1'b1;
        vec.slot  = SLOT_W'(i);
        vec.src   = slots[i].src;
      end
    end
  end

endmodule : slot_picker

// >>> logic/vectored_interrupt_router.sv
/*
  Vectored interrupt router: conditions 54 sources, masks and routes them to
  the normal and fast processor requests, and vectors them through priority slots.
  Assumes an APB master on pclk; GPIO and external lines are asynchronous pins,
  peripheral lines come from logic on pclk.
*/
`timescale 1ns/1ps
module vectored_interrupt_router
  import irq_router_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [N_INT-1:0]  periph_irq,
  input  wire logic [N_GPIO-1:0] gpio_pin,
  input  wire logic [N_EXT-1:0]  ext_irq_pin,
  output logic                   normal_irq,
  output logic                   fast_interrupt_request,
  output logic                   irq
);

  function automatic logic is_nslot(input logic [ADDR_W-1:0] a);
    return (a >= OFF_NSLOT) && (a < OFF_NSLOT_END);
  endfunction : is_nslot

  function automatic logic [SLOT_W-1:0] nslot_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - OFF_NSLOT;
    return off[SLOT_W+1:2];
  endfunction : nslot_idx

  logic setup;
  logic wr;
  logic rd_done;

  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pready & pwrite;
  assign rd_done = psel & penable & pready & ~pwrite;

  // Configuration registers.
  src_vec_t                  en;
  src_vec_t                  route;
  src_vec_t                  pol;
  logic [N_GPIO-1:0]         gpio_edge;
  logic [N_GPIO-1:0]         gpio_pol;
  logic [N_GPIO-1:0]         gpio_both;
  logic [N_EVT-1:0]          evt_mask;
  slot_t [N_NSLOT-1:0]       nslot;
  slot_t [N_FSLOT-1:0]       fslot;

  src_vec_t                  next_en;
  src_vec_t                  next_route;
  src_vec_t                  next_pol;
  logic [N_GPIO-1:0]         next_gpio_edge;
  logic [N_GPIO-1:0]         next_gpio_pol;
  logic [N_GPIO-1:0]         next_gpio_both;
  logic [N_EVT-1:0]          next_evt_mask;
  slot_t [N_NSLOT-1:0]       next_nslot;
  slot_t [N_FSLOT-1:0]       next_fslot;

  always_comb begin
    next_en        = en;
    next_route     = route;
    next_pol       = pol;
    next_gpio_edge = gpio_edge;
    next_gpio_pol  = gpio_pol;
    next_gpio_both = gpio_both;
    next_evt_mask  = evt_mask;
    next_nslot     = nslot;
    next_fslot     = fslot;
    if (wr) begin
      case (paddr)
        OFF_EN_LO: begin
          next_en[31:0] = pwdata;
        end
        OFF_EN_HI: begin
          next_en[N_SRC-1:32] = pwdata[N_SRC-33:0];
        end
        OFF_ROUTE_LO: begin
          next_route[31:0] = pwdata;
        end
        OFF_ROUTE_HI: begin
          next_route[N_SRC-1:32] = pwdata[N_SRC-33:0];
        end
        OFF_POL_LO: begin
          next_pol[31:0] = pwdata;
        end
        OFF_POL_HI: begin
          next_pol[N_SRC-1:32] = pwdata[N_SRC-33:0];
        end
        OFF_GPIO_EDGE: begin
          next_gpio_edge = pwdata[N_GPIO-1:0];
        end
        OFF_GPIO_POL: begin
          next_gpio_pol = pwdata[N_GPIO-1:0];
        end
        OFF_GPIO_BOTH: begin
          next_gpio_both = pwdata[N_GPIO-1:0];
        end
        OFF_EVT_MASK: begin
          next_evt_mask = pwdata[N_EVT-1:0];
        end
        OFF_FSLOT0, OFF_FSLOT1: begin
          next_fslot[paddr[2]] = slot_t'(pwdata[SLOT_EN_BIT:0]);
        end
        default: begin
          if (is_nslot(paddr)) begin
            next_nslot[nslot_idx(paddr)] = slot_t'(pwdata[SLOT_EN_BIT:0]);
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en        <= '0;
      route     <= '0;
      pol       <= '0;
      gpio_edge <= '0;
      gpio_pol  <= '0;
      gpio_both <= '0;
      evt_mask  <= '0;
      nslot     <= '0;
      fslot     <= '0;
    end else begin
      en        <= next_en;
      route     <= next_route;
      pol       <= next_pol;
      gpio_edge <= next_gpio_edge;
      gpio_pol  <= next_gpio_pol;
      gpio_both <= next_gpio_both;
      evt_mask  <= next_evt_mask;
      nslot     <= next_nslot;
      fslot     <= next_fslot;
    end
  end

  // Pin conditioning.
  logic [N_GPIO+N_EXT-1:0] pins_s;
  logic [N_GPIO-1:0]       gpio_s;
  logic [N_EXT-1:0]        ext_s;

  pin_sync #(
    .WIDTH (N_GPIO + N_EXT)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     ({ext_irq_pin, gpio_pin}),
    .level   (pins_s)
  );

  assign gpio_s = pins_s[N_GPIO-1:0];
  assign ext_s  = pins_s[N_GPIO+N_EXT-1:N_GPIO];

  // Source conditioning and request state.
  logic [N_GPIO-1:0] gpio_prev;
  logic [N_GPIO-1:0] gpio_latch;
  src_vec_t          raw;
  logic [N_EVT-1:0]  evt_stat;
  logic              normal_req;
  logic              fast_req;

  logic [N_GPIO-1:0] next_gpio_latch;
  src_vec_t          next_raw;
  logic [N_EVT-1:0]  next_evt_stat;
  logic              next_normal_req;
  logic              next_fast_req;
  logic              next_irq;

  logic [N_GPIO-1:0] rise;
  logic [N_GPIO-1:0] fall;
  logic [N_GPIO-1:0] hit;
  logic [N_GPIO-1:0] clr;
  logic [N_EVT-1:0]  evt_set;
  logic [N_EVT-1:0]  evt_clr;
  src_vec_t          live;

  always_comb begin
    int k;
    k = 0;
    rise = gpio_s & ~gpio_prev;
    fall = ~gpio_s & gpio_prev;
    hit  = (gpio_both & (rise | fall))
         | (~gpio_both & ((~gpio_pol & rise) | (gpio_pol & fall)));
    clr  = (wr && paddr == OFF_GPIO_CLR) ? pwdata[N_GPIO-1:0] : '0;
    // A new edge in the clearing cycle survives; leaving edge mode drops the latch.
    next_gpio_latch = ((gpio_latch & ~clr) | hit) & gpio_edge;
    next_raw = '0;
    for (int i = 0; i < N_SRC; i++) begin
      if (i < N_GPIO) begin
        next_raw[i] = gpio_edge[i] ? gpio_latch[i] : (gpio_s[i] ^ gpio_pol[i]);
      end else if (i == EXT_SRC5) begin
        next_raw[i] = ext_s[0];
      end else if (i == EXT_SRC6) begin
        next_raw[i] = ext_s[1];
      end else if (i == EXT_SRC7) begin
        next_raw[i] = ext_s[2];
      end else begin
        next_raw[i] = periph_irq[k] ^ pol[i];
        k = k + 1;
      end
    end
    live            = raw & en;
    next_normal_req = |(live & ~route);
    next_fast_req   = |(live & route);
    evt_set[EVT_NORMAL] = next_normal_req & ~normal_req;
    evt_set[EVT_FAST]   = next_fast_req & ~fast_req;
    // Only bits that the read returned are cleared, so a fresh event is kept.
    evt_clr       = (rd_done && paddr == OFF_EVT_STAT) ? prdata[N_EVT-1:0] : '0;
    next_evt_stat = (evt_stat & ~evt_clr) | evt_set;
    next_irq      = |(next_evt_stat & evt_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_prev              <= '0;
      gpio_latch             <= '0;
      raw                    <= '0;
      evt_stat               <= '0;
      normal_req             <= 1'b0;
      fast_req               <= 1'b0;
      normal_irq             <= 1'b0;
      fast_interrupt_request <= 1'b0;
      irq                    <= 1'b0;
    end else begin
      gpio_prev              <= gpio_s;
      gpio_latch             <= next_gpio_latch;
      raw                    <= next_raw;
      evt_stat               <= next_evt_stat;
      normal_req             <= next_normal_req;
      fast_req               <= next_fast_req;
      normal_irq             <= next_normal_req;
      fast_interrupt_request <= next_fast_req;
      irq                    <= next_irq;
    end
  end

  // Vectoring: lowest enabled slot wins on each path.
  vec_t nvec;
  vec_t fvec;

  slot_picker #(
    .N_SLOTS (N_NSLOT)
  ) u_normal_pick (
    .pend  (raw & en & ~route),
    .slots (nslot),
    .vec   (nvec)
  );

  slot_picker #(
    .N_SLOTS (N_FSLOT)
  ) u_fast_pick (
    .pend  (raw & en & route),
    .slots (fslot),
    .vec   (fvec)
  );

  function automatic logic [31:0] vec_word(input vec_t v);
    logic [31:0] w;
    w = RST_WORD;
    w[VEC_VALID_BIT] = v.valid;
    w[VEC_SLOT_LSB +: SLOT_W] = v.slot;
    w[VEC_SRC_LSB +: SRC_W] = v.src;
    return w;
  endfunction : vec_word

  // APB response: data is sampled in the setup cycle, so every access takes one wait-free
  // access phase; status seen by software is at most one cycle old.
  logic [31:0] rdata;
  logic        mapped;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  always_comb begin
    rdata  = RST_WORD;
    mapped = 1'b1;
    case (paddr)
      OFF_RAW_LO:    rdata = raw[31:0];
      OFF_RAW_HI:    rdata[N_SRC-33:0] = raw[N_SRC-1:32];
      OFF_EN_LO:     rdata = en[31:0];
      OFF_EN_HI:     rdata[N_SRC-33:0] = en[N_SRC-1:32];
      OFF_ROUTE_LO:  rdata = route[31:0];
      OFF_ROUTE_HI:  rdata[N_SRC-33:0] = route[N_SRC-1:32];
      OFF_POL_LO:    rdata = pol[31:0];
      OFF_POL_HI:    rdata[N_SRC-33:0] = pol[N_SRC-1:32];
      OFF_GPIO_EDGE: rdata[N_GPIO-1:0] = gpio_edge;
      OFF_GPIO_POL:  rdata[N_GPIO-1:0] = gpio_pol;
      OFF_GPIO_BOTH: rdata[N_GPIO-1:0] = gpio_both;
      OFF_GPIO_CLR:  rdata[N_GPIO-1:0] = gpio_latch;
      OFF_NVEC:      rdata = vec_word(nvec);
      OFF_FVEC:      rdata = vec_word(fvec);
      OFF_EVT_STAT:  rdata[N_EVT-1:0] = evt_stat;
      OFF_EVT_MASK:  rdata[N_EVT-1:0] = evt_mask;
      OFF_FSLOT0:    rdata[SLOT_EN_BIT:0] = fslot[0];
      OFF_FSLOT1:    rdata[SLOT_EN_BIT:0] = fslot[1];
      default: begin
        if (is_nslot(paddr)) begin
          rdata[SLOT_EN_BIT:0] = nslot[nslot_idx(paddr)];
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
    next_pready  = setup;
    next_pslverr = setup & ~mapped;
    next_prdata  = setup ? rdata : prdata;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= RST_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

endmodule : vectored_interrupt_router

// >>> test/vir_chk.sv
/*
  Port checker for the vectored interrupt router.
  Assumes it is bound to the top module and sees only that module's ports.
*/
`timescale 1ns/1ps
module vir_chk
  import irq_router_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [N_INT-1:0]  periph_irq,
  input wire logic [N_GPIO-1:0] gpio_pin,
  input wire logic [N_EXT-1:0]  ext_irq_pin,
  input wire logic              normal_irq,
  input wire logic              fast_interrupt_request,
  input wire logic              irq
);
  // Shadows of the enable halves and the normal event mask, kept from bus writes.
  logic [1:0] en_nz;
  logic [1:0] next_en_nz;
  logic       mask_n;
  logic       next_mask_n;
  logic       wr_acc;

  assign wr_acc = psel && penable && pready && pwrite;

  always_comb begin
    next_en_nz  = en_nz;
    next_mask_n = mask_n;
    if (wr_acc && (paddr == OFF_EN_LO || paddr == OFF_EN_HI)) begin
      next_en_nz[paddr[2]] = |pwdata;
    end
    if (wr_acc && paddr == OFF_EVT_MASK) begin
      next_mask_n = pwdata[EVT_NORMAL];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_nz  <= 2'h0;
      mask_n <= 1'b0;
    end else begin
      en_nz  <= next_en_nz;
      mask_n <= next_mask_n;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready_after_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("ready missing after setup");
  property p_ready_once;
    pready |=> !pready;
  endproperty
  a_ready_once: assert property (p_ready_once)
    else $error("ready longer than one cycle");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("error without ready");
  property p_err_read_zero;
    pready && pslverr && !pwrite |-> prdata == 32'h0000_0000;
  endproperty
  a_err_read_zero: assert property (p_err_read_zero)
    else $error("refused read returned data");
  property p_rdata_hold;
    !(psel && !penable) |=> $stable(prdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved outside setup");
  property p_quiet_after_reset;
    $rose(presetn) |-> !normal_irq && !fast_interrupt_request && !irq && !pready;
  endproperty
  a_quiet_after_reset: assert property (p_quiet_after_reset)
    else $error("output active after reset");
  property p_masked_quiet;
    (en_nz == 2'h0) ##1 (en_nz == 2'h0) |-> !normal_irq && !fast_interrupt_request;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("request while every source disabled");
  property p_event_irq;
    $rose(normal_irq) && mask_n |=> irq;
  endproperty
  a_event_irq: assert property (p_event_irq)
    else $error("unmasked event gave no interrupt");

  c_refused: cover property (pready && pslverr);
  c_fast: cover property ($rose(fast_interrupt_request));
  c_irq: cover property ($rose(irq));
endmodule : vir_chk

bind vectored_interrupt_router vir_chk i_vir_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .periph_irq, .gpio_pin, .ext_irq_pin, .normal_irq,
  .fast_interrupt_request, .irq
);

// >>> test/core_model.sv
/*
  Processor core model: counts the rises of the normal and fast requests.
  Assumes both requests are levels on pclk.
*/
`timescale 1ns/1ps
module core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic normal_irq,
  input wire logic fast_interrupt_request,
  output int       normal_seen,
  output int       fast_seen
);
  logic prev_n;
  logic prev_f;

  // The core takes each request on its own input; both are counted apart.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_n <= 1'b0;
      prev_f <= 1'b0;
      normal_seen <= 0;
      fast_seen <= 0;
    end else begin
      prev_n <= normal_irq;
      prev_f <= fast_interrupt_request;
      if (normal_irq && !prev_n) normal_seen <= normal_seen + 1;
      if (fast_interrupt_request && !prev_f) fast_seen <= fast_seen + 1;
    end
  end
endmodule : core_model

// >>> test/test_vectored_interrupt_router.sv
/*
  Testbench of the vectored interrupt router: APB tasks and directed sequences.
  Assumes the checker is bound in and the core model watches the requests.
*/
`timescale 1ns/1ps
module test_vectored_interrupt_router
  import irq_router_pkg::*;
;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [N_INT-1:0]  periph_irq = 32'h0000_0000;
  logic [N_GPIO-1:0] gpio_pin = 19'h0_0000;
  logic [N_EXT-1:0]  ext_irq_pin = 3'h0;
  logic              normal_irq;
  logic              fast_interrupt_request;
  logic              irq;
  logic [2:0]        outs;
  logic [31:0]       q;
  logic              e;
  int                num_errors = 0;
  int                checks_done = 0;
  int                normal_seen;
  int                fast_seen;
  // Per GPIO mode: edge, pol, both, idle level, after toggle, after clear, after return.
  logic [6:0]        gmode [5] = '{7'h06, 7'h2E, 7'h44, 7'h6C, 7'h55};
  logic [31:0]       raw_lo [3] = '{32'h0040_0000, 32'h0000_0000, 32'h0000_0000};
  logic [31:0]       raw_hi [3] = '{32'h0000_0000, 32'h0000_0002, 32'h0000_0100};
  // Normal vector per external line: slot 31 holds source 22, slot 0 source 33, none 40.
  logic [31:0]       nv [3] = '{32'h8000_161F, 32'h8000_2100, 32'h0000_0000};

  assign outs = {irq, fast_interrupt_request, normal_irq};
  always #10 pclk = ~pclk;

  vectored_interrupt_router i_vectored_interrupt_router (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .periph_irq, .gpio_pin, .ext_irq_pin, .normal_irq,
    .fast_interrupt_request, .irq
  );
  core_model i_core_model (
    .pclk, .presetn, .normal_irq, .fast_interrupt_request, .normal_seen, .fast_seen
  );

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      check({31'h0000_0000, pready}, 32'h0000_0001);
      complete_run();
    end
  endtask : xfer

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask : rd

  task automatic rg(input logic b);
    xfer(1'b0, OFF_RAW_LO, 32'h0000_0000);
    check({31'h0000_0000, q[18]}, {31'h0000_0000, b});
  endtask : rg

  task automatic wait_lvl(input int k, input logic v);
    int n;
    n = 0;
    while (outs[k] !== v && n < 32) begin
      @(posedge pclk);
      n++;
    end
    check({31'h0000_0000, outs[k]}, {31'h0000_0000, v});
    if (n >= 32) complete_run();
  endtask : wait_lvl

  function automatic logic [31:0] bit18(input logic b);
    return {13'h0000, b, 18'h0_0000};
  endfunction : bit18

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_EN_LO, 32'h0000_0000);
    wr(OFF_RAW_LO, 32'hFFFF_FFFF);
    rd(OFF_RAW_LO, 32'h0000_0000);
    rd(8'hFC, 32'h0000_0000);
    check({31'h0000_0000, e}, 32'h0000_0001);
    // Peripheral line 0 is source 19, vectored through normal slot 1.
    wr(OFF_EN_LO, 32'h0008_0000);
    wr(OFF_EVT_MASK, 32'h0000_0001);
    wr(OFF_NSLOT + 8'h04, 32'h0000_0053);
    periph_irq[0] <= 1'b1;
    wait_lvl(0, 1'b1);
    wait_lvl(2, 1'b1);
    rd(OFF_NVEC, 32'h8000_1301);
    rd(OFF_EVT_STAT, 32'h0000_0001);
    rd(OFF_EVT_STAT, 32'h0000_0000);
    wr(OFF_POL_LO, 32'h0008_0000);
    wait_lvl(0, 1'b0);
    periph_irq[0] <= 1'b0;
    wait_lvl(0, 1'b1);
    wr(OFF_EVT_MASK, 32'h0000_0002);
    wr(OFF_ROUTE_LO, 32'h0008_0000);
    wr(OFF_FSLOT1, 32'h0000_0053);
    wait_lvl(1, 1'b1);
    wait_lvl(0, 1'b0);
    rd(OFF_FVEC, 32'h8000_1301);
    rd(OFF_EVT_STAT, 32'h0000_0003);
    wait_lvl(2, 1'b0);
    wr(OFF_EN_LO, 32'h0000_0000);
    wait_lvl(1, 1'b0);
    // Polarity set on the external sources must have no effect.
    wr(OFF_POL_LO, 32'h0040_0000);
    wr(OFF_POL_HI, 32'h0000_0102);
    wr(OFF_ROUTE_LO, 32'h0000_0000);
    wr(OFF_EVT_MASK, 32'h0000_0000);
    wr(OFF_EN_LO, 32'hFFFF_FFFF);
    wr(OFF_EN_HI, 32'h003F_FFFF);
    wr(OFF_NSLOT, 32'h0000_0061);
    wr(OFF_NSLOT + 8'h7C, 32'h0000_0056);
    for (int k = 0; k < 3; k++) begin
      ext_irq_pin[k] <= 1'b1;
      wait_lvl(0, 1'b1);
      rd(OFF_RAW_LO, raw_lo[k]);
      rd(OFF_RAW_HI, raw_hi[k]);
      rd(OFF_NVEC, nv[k]);
      ext_irq_pin[k] <= 1'b0;
      wait_lvl(0, 1'b0);
    end
    check({31'h0000_0000, irq}, 32'h0000_0000);
    rd(OFF_EVT_STAT, 32'h0000_0001);
    // Two rises from peripheral line 0 and one from each external line.
    check(32'(normal_seen), 32'h0000_0005);
    // GPIO 18 through every sensitivity; pins settle well inside ten cycles.
    for (int m = 0; m < 5; m++) begin
      gpio_pin[18] <= gmode[m][3];
      repeat (10) @(posedge pclk);
      wr(OFF_GPIO_EDGE, bit18(gmode[m][6]));
      wr(OFF_GPIO_POL, bit18(gmode[m][5]));
      wr(OFF_GPIO_BOTH, bit18(gmode[m][4]));
      wr(OFF_GPIO_CLR, 32'h0004_0000);
      rg(1'b0);
      gpio_pin[18] <= !gmode[m][3];
      repeat (10) @(posedge pclk);
      rg(gmode[m][2]);
      wr(OFF_GPIO_CLR, 32'h0004_0000);
      rg(gmode[m][1]);
      gpio_pin[18] <= gmode[m][3];
      repeat (10) @(posedge pclk);
      rg(gmode[m][0]);
    end
    check(32'(fast_seen), 32'h0000_0001);
    complete_run();
  end
endmodule : test_vectored_interrupt_router
